//--- src/dsprm_consts.svh
// Register offsets, field positions and reset values of the parameter bank
`ifndef DSPRM_CONSTS_SVH
`define DSPRM_CONSTS_SVH

`define DSPRM_OFS_CTRL     12'h000
`define DSPRM_OFS_ADDR     12'h004
`define DSPRM_OFS_LEN      12'h008
`define DSPRM_OFS_DATA     12'h00c
`define DSPRM_OFS_CH0      12'h010
`define DSPRM_OFS_CH1      12'h014
`define DSPRM_OFS_ID       12'h018
`define DSPRM_OFS_STAT     12'h01c

`define DSPRM_RST_WORD     32'h00000000
`define DSPRM_WORD_LO      2
`define DSPRM_OPERATION_ACCESS_SELECTOR_HI      1
`define DSPRM_CTRL_CSUM    2
`define DSPRM_CTRL_MEMORY_SELF_TEST   3
`define DSPRM_STAT_BUSY    0
`define DSPRM_STAT_DONE    1
`define DSPRM_STAT_DIRTY0  2
`define DSPRM_STAT_DIRTY1  3

// Identity fields; values are arbitrary
`define DSPRM_ID_PROC      4'h5
`define DSPRM_ID_FAMILY    5'h0a
`define DSPRM_ID_SERIES    6'h15
`define DSPRM_ID_DIE       4'h3
`define DSPRM_ID_REV       4'h2
`define DSPRM_ID_VARIANT   8'h5a

`endif

//--- src/dsprm_pkg.sv
// Types used by the parameter bank: operation encoding and register state
package dsprm_pkg;
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_CSUM,
        OP_MEMORY_SELF_TEST
    } dsprm_op_e;

    typedef struct packed {
        logic [31:0] start_addr;
        logic [29:0] word_len;
        logic [31:0] seed_result;
        logic [31:0] chan0;
        logic [31:0] chan1;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        csum_start;
        logic        memory_self_test_start;
        dsprm_op_e   op;
        logic        done;
    } dsprm_state_s;
endpackage

//--- src/dsprm_flag_if.sv
// Channel access strobes and dirty flags between bank and flag module
`timescale 1ns/1ps
interface dsprm_flag_if;
    logic [1:0] wr_hit;
    logic [1:0] rd_hit;
    logic [1:0] dirty;
    modport bank (output wr_hit, output rd_hit, input dirty);
    modport flags (input wr_hit, input rd_hit, output dirty);
endinterface

//--- src/dsprm_dirty_flags.sv
// Per-channel dirty flags, set on write, cleared on read
`timescale 1ns/1ps
module dsprm_dirty_flags (
    // Clock and reset
    input wire logic    sys_clk,
    input wire logic    reset,
    // Channel strobes
    dsprm_flag_if.flags fl
);
    typedef struct packed {
        logic [1:0] dirty;
    } dsprm_flag_state_s;

    dsprm_flag_state_s st;
    dsprm_flag_state_s next_st;

    // ----------------------------------------
    // Flag update
    // ----------------------------------------
    always_comb begin
        next_st = st;
        for (int i = 0; i < 2; i++) begin
            if (fl.wr_hit[i]) begin
                next_st.dirty[i] = 1'b1;
            end else if (fl.rd_hit[i]) begin
                next_st.dirty[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fl.dirty = st.dirty;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chk
            property p_dirty_set;
                @(posedge sys_clk) disable iff (reset)
                fl.wr_hit[g] |=> fl.dirty[g];
            endproperty
            a_dirty_set: assert property (p_dirty_set) else $error("dirty flag not set by write");

            property p_dirty_clr;
                @(posedge sys_clk) disable iff (reset)
                (fl.rd_hit[g] && !fl.wr_hit[g]) |=> !fl.dirty[g];
            endproperty
            a_dirty_clr: assert property (p_dirty_clr) else $error("dirty flag not cleared by read");
        end
    endgenerate
endmodule

//--- src/dsprm_bank.sv
// Parameter and identity register bank of the debug service unit, APB slave
//
// Operation
// - Start address bits 31:2 hold a word address; operations start word aligned.
// - Address bits 1:0 select access mode, meaning depends on checksum or self-test.
// - Length bits 31:2 give operation size in words; bits 1:0 unimplemented.
// - Data register seeds the operation and receives its result on completion.
// - Two 32-bit channel registers at 0x10 and 0x14, reset to zero, unguarded.
// - Identity word at 0x18: processor 31:28, family 27:23, series 21:16.
// - Identity bits 15:12 give the fixed die number.
// - Channel dirty flag sets on channel write, clears on channel read.
// - Identity bits 11:8 give die revision, zero is the first revision.
// - Writing one to the checksum start bit launches it when no operation is running; zero does nothing.
`timescale 1ns/1ps
`include "dsprm_consts.svh"
module dsprm_bank (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Operation engine
    output logic [29:0]      op_word_addr,
    output logic [1:0]       operation_access_selector,
    output logic [29:0]      op_word_count,
    output logic [31:0]      op_seed,
    output logic             op_csum_start,
    output logic             op_memory_self_test_start,
    input  wire logic        op_done,
    input  wire logic [31:0] op_result
);
    dsprm_pkg::dsprm_state_s st;
    dsprm_pkg::dsprm_state_s next_st;
    dsprm_flag_if            fl ();

    logic [31:0] id_word;
    logic        setup;
    logic        wr_req;
    logic        rd_req;
    logic        mapped;

    dsprm_dirty_flags u_flags (
        .sys_clk (sys_clk),
        .reset   (reset),
        .fl      (fl)
    );

    // ----------------------------------------
    // Identity word
    // ----------------------------------------
    assign id_word = {`DSPRM_ID_PROC, `DSPRM_ID_FAMILY, 1'b0, `DSPRM_ID_SERIES,
                      `DSPRM_ID_DIE, `DSPRM_ID_REV, `DSPRM_ID_VARIANT};

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // One wait state: the answer is prepared in the first access cycle
    assign setup  = psel && penable && !st.pready;
    assign wr_req = setup && pwrite;
    assign rd_req = setup && !pwrite;

    always_comb begin
        case (paddr)
            `DSPRM_OFS_CTRL, `DSPRM_OFS_ADDR, `DSPRM_OFS_LEN, `DSPRM_OFS_DATA,
            `DSPRM_OFS_CH0, `DSPRM_OFS_CH1, `DSPRM_OFS_ID, `DSPRM_OFS_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign fl.wr_hit = {wr_req && paddr == `DSPRM_OFS_CH1,
                        wr_req && paddr == `DSPRM_OFS_CH0};
    assign fl.rd_hit = {rd_req && paddr == `DSPRM_OFS_CH1,
                        rd_req && paddr == `DSPRM_OFS_CH0};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st          = st;
        next_st.pready   = setup;
        next_st.pslverr  = setup && !mapped;
        next_st.csum_start  = 1'b0;
        next_st.memory_self_test_start = 1'b0;
        if (!setup) begin
            next_st.prdata = `DSPRM_RST_WORD;
        end
        // Engine result lands in the data register
        if (op_done && st.op != dsprm_pkg::OP_IDLE) begin
            next_st.seed_result = op_result;
            next_st.op          = dsprm_pkg::OP_IDLE;
            next_st.done        = 1'b1;
        end
        if (wr_req) begin
            case (paddr)
                `DSPRM_OFS_CTRL: begin
                    if (pwdata[`DSPRM_CTRL_CSUM] && st.op == dsprm_pkg::OP_IDLE) begin
                        next_st.op         = dsprm_pkg::OP_CSUM;
                        next_st.csum_start = 1'b1;
                        next_st.done     = 1'b0;
                    end else if (pwdata[`DSPRM_CTRL_MEMORY_SELF_TEST] && st.op == dsprm_pkg::OP_IDLE) begin
                        next_st.op          = dsprm_pkg::OP_MEMORY_SELF_TEST;
                        next_st.memory_self_test_start = 1'b1;
                        next_st.done     = 1'b0;
                    end
                end
                `DSPRM_OFS_ADDR: next_st.start_addr = pwdata;
                `DSPRM_OFS_LEN:  next_st.word_len = pwdata[31:`DSPRM_WORD_LO];
                `DSPRM_OFS_DATA: next_st.seed_result = pwdata;
                `DSPRM_OFS_CH0:  next_st.chan0 = pwdata;
                `DSPRM_OFS_CH1:  next_st.chan1 = pwdata;
                default: begin
                end
            endcase
        end
        if (rd_req) begin
            case (paddr)
                `DSPRM_OFS_ADDR: next_st.prdata = st.start_addr;
                `DSPRM_OFS_LEN:  next_st.prdata = {st.word_len, 2'b00};
                `DSPRM_OFS_DATA: next_st.prdata = st.seed_result;
                `DSPRM_OFS_CH0:  next_st.prdata = st.chan0;
                `DSPRM_OFS_CH1:  next_st.prdata = st.chan1;
                `DSPRM_OFS_ID:   next_st.prdata = id_word;
                `DSPRM_OFS_STAT: begin
                    next_st.prdata = `DSPRM_RST_WORD;
                    next_st.prdata[`DSPRM_STAT_BUSY]   = st.op != dsprm_pkg::OP_IDLE;
                    next_st.prdata[`DSPRM_STAT_DONE]   = st.done;
                    next_st.prdata[`DSPRM_STAT_DIRTY0] = fl.dirty[0];
                    next_st.prdata[`DSPRM_STAT_DIRTY1] = fl.dirty[1];
                end
                default: next_st.prdata = `DSPRM_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pready                    = st.pready;
    assign prdata                    = st.prdata;
    assign pslverr                   = st.pslverr;
    assign op_word_addr              = st.start_addr[31:`DSPRM_WORD_LO];
    assign operation_access_selector = st.start_addr[`DSPRM_OPERATION_ACCESS_SELECTOR_HI:0];
    assign op_word_count             = st.word_len;
    assign op_seed                   = st.seed_result;
    assign op_csum_start             = st.csum_start;
    assign op_memory_self_test_start            = st.memory_self_test_start;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_csum_launch;
        @(posedge sys_clk) disable iff (reset)
        (wr_req && paddr == `DSPRM_OFS_CTRL && pwdata[`DSPRM_CTRL_CSUM] && st.op == dsprm_pkg::OP_IDLE)
            |=> op_csum_start ##1 !op_csum_start;
    endproperty
    a_csum_launch: assert property (p_csum_launch) else $error("checksum launch missing");

    property p_csum_zero;
        @(posedge sys_clk) disable iff (reset)
        (wr_req && paddr == `DSPRM_OFS_CTRL && !pwdata[`DSPRM_CTRL_CSUM]) |=> !op_csum_start;
    endproperty
    a_csum_zero: assert property (p_csum_zero) else $error("checksum started by zero");

    property p_addr_split;
        @(posedge sys_clk) disable iff (reset)
        (wr_req && paddr == `DSPRM_OFS_ADDR)
            |=> (op_word_addr == $past(pwdata[31:2]) && operation_access_selector == $past(pwdata[1:0]));
    endproperty
    a_addr_split: assert property (p_addr_split) else $error("address fields wrong");

    property p_len_read;
        @(posedge sys_clk) disable iff (reset)
        (rd_req && paddr == `DSPRM_OFS_LEN) |=> (prdata[1:0] == 2'h0 && prdata[31:2] == op_word_count);
    endproperty
    a_len_read: assert property (p_len_read) else $error("length read wrong");

    property p_result;
        @(posedge sys_clk) disable iff (reset)
        (op_done && st.op != dsprm_pkg::OP_IDLE && !(wr_req && paddr == `DSPRM_OFS_DATA))
            |=> op_seed == $past(op_result);
    endproperty
    a_result: assert property (p_result) else $error("result not stored");

    property p_chan_rw;
        @(posedge sys_clk) disable iff (reset)
        (wr_req && paddr == `DSPRM_OFS_CH1) ##2 (psel && !penable && !pwrite && paddr == `DSPRM_OFS_CH1)
            ##1 rd_req |=> prdata == $past(pwdata, 4);
    endproperty
    a_chan_rw: assert property (p_chan_rw) else $error("channel one readback wrong");

    property p_id_read;
        @(posedge sys_clk) disable iff (reset)
        (rd_req && paddr == `DSPRM_OFS_ID) |=> (pready && prdata[31:28] == `DSPRM_ID_PROC
            && prdata[27:23] == `DSPRM_ID_FAMILY && prdata[21:16] == `DSPRM_ID_SERIES);
    endproperty
    a_id_read: assert property (p_id_read) else $error("identity fields wrong");

    property p_id_die_rev;
        @(posedge sys_clk) disable iff (reset)
        (rd_req && paddr == `DSPRM_OFS_ID)
            |=> (prdata[15:12] == `DSPRM_ID_DIE && prdata[11:8] == `DSPRM_ID_REV);
    endproperty
    a_id_die_rev: assert property (p_id_die_rev) else $error("die or revision wrong");

    property p_answer;
        @(posedge sys_clk) disable iff (reset)
        (psel && !penable) ##1 (psel && penable) |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing wrong");

    property p_id_write;
        @(posedge sys_clk) disable iff (reset)
        (wr_req && paddr == `DSPRM_OFS_ID && !op_done)
            |=> (!pslverr && op_seed == $past(op_seed) && op_word_count == $past(op_word_count));
    endproperty
    a_id_write: assert property (p_id_write) else $error("identity write disturbed the bank");
endmodule

//--- verif/dsprm_engine_model.sv
// Behavioural operation engine answering start pulses after a delay
`timescale 1ns/1ps
module dsprm_engine_model #(
    parameter int DELAY = 6
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Bank side
    input  wire logic        op_start,
    input  wire logic [31:0] op_seed,
    input  wire logic [29:0] op_word_count,
    output logic             op_done,
    output logic [31:0]      op_result
);
    int left;
    always @(posedge sys_clk) begin
        op_done <= 1'b0;
        if (reset) begin
            left <= 0;
            op_result <= 32'h0;
        end else if (op_start) begin
            left <= DELAY;
            // Result is meaningless outside the done pulse
            op_result <= ~op_result;
        end else if (left == 1) begin
            left <= 0;
            op_done <= 1'b1;
            op_result <= op_seed + {2'h0, op_word_count};
        end else if (left > 1) begin
            left <= left - 1;
        end
    end
endmodule

//--- verif/debug_service_param_regs_tb.sv
// Self-checking bench for the parameter bank over APB
`timescale 1ns/1ps
`include "dsprm_consts.svh"
module debug_service_param_regs_tb;
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic        err;
    } dsprm_row_s;
    localparam logic [31:0] ID_WORD = {`DSPRM_ID_PROC, `DSPRM_ID_FAMILY, 1'b0, `DSPRM_ID_SERIES,
                                       `DSPRM_ID_DIE, `DSPRM_ID_REV, `DSPRM_ID_VARIANT};
    localparam dsprm_row_s ROWS [14] = '{
        '{1'b1, `DSPRM_OFS_ADDR, 32'hffffffff, 32'h0, 1'b0}, '{1'b0, `DSPRM_OFS_ADDR, 32'h0, 32'hffffffff, 1'b0},
        '{1'b1, `DSPRM_OFS_LEN, 32'hffffffff, 32'h0, 1'b0}, '{1'b0, `DSPRM_OFS_LEN, 32'h0, 32'hfffffffc, 1'b0},
        '{1'b1, `DSPRM_OFS_DATA, 32'ha5a5a5a5, 32'h0, 1'b0}, '{1'b0, `DSPRM_OFS_DATA, 32'h0, 32'ha5a5a5a5, 1'b0},
        '{1'b1, `DSPRM_OFS_CH0, 32'h12345678, 32'h0, 1'b0}, '{1'b0, `DSPRM_OFS_CH0, 32'h0, 32'h12345678, 1'b0},
        '{1'b1, `DSPRM_OFS_CH1, 32'h9abcdef0, 32'h0, 1'b0}, '{1'b0, `DSPRM_OFS_CH1, 32'h0, 32'h9abcdef0, 1'b0},
        '{1'b1, `DSPRM_OFS_ID, 32'hffffffff, 32'h0, 1'b0}, '{1'b0, `DSPRM_OFS_ID, 32'h0, ID_WORD, 1'b0},
        '{1'b1, 12'h020, 32'hffffffff, 32'h0, 1'b1}, '{1'b0, 12'h020, 32'h0, 32'h0, 1'b1}};
    localparam logic [11:0] RST_OFS [6] = '{`DSPRM_OFS_ADDR, `DSPRM_OFS_LEN, `DSPRM_OFS_DATA,
                                            `DSPRM_OFS_CH0, `DSPRM_OFS_CH1, `DSPRM_OFS_STAT};
    logic        sys_clk = 1'b0;
    logic        reset, psel, penable, pwrite, pready, pslverr, op_done, op_csum_start, op_memory_self_test_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, op_seed, op_result, rd_data;
    logic [29:0] op_word_addr, op_word_count;
    logic [1:0]  operation_access_selector;
    logic        rd_err;
    int          fail_count = 0;
    int          tests_run = 0;
    int          csum_cnt = 0;
    int          memory_self_test_cnt = 0;

    always #2.5 sys_clk = ~sys_clk;
    // Start pulses counted mid-cycle, where they are settled
    always @(negedge sys_clk) begin
        if (op_csum_start === 1'b1) csum_cnt++;
        if (op_memory_self_test_start === 1'b1) memory_self_test_cnt++;
    end

    dsprm_bank DUT (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .op_word_addr(op_word_addr), .operation_access_selector(operation_access_selector),
        .op_word_count(op_word_count), .op_seed(op_seed), .op_csum_start(op_csum_start),
        .op_memory_self_test_start(op_memory_self_test_start), .op_done(op_done), .op_result(op_result));
    dsprm_engine_model ENG (.sys_clk(sys_clk), .reset(reset), .op_start(op_csum_start | op_memory_self_test_start),
        .op_seed(op_seed), .op_word_count(op_word_count), .op_done(op_done), .op_result(op_result));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer, started just after a rising edge; answer taken at the edge where pready is high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, input bit last = 1'b1);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            test_done();
        end
        rd_data = prdata;
        rd_err = pslverr;
        penable <= 1'b0;
        // Back-to-back transfers keep psel; the last one lets an idle edge pass
        if (last) begin
            psel <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, `DSPRM_OFS_STAT, 32'h0);
            n++;
        end while (rd_data[`DSPRM_STAT_DONE] !== 1'b1 && n < 20);
        chk("done flag", 32'h1, {31'h0, rd_data[`DSPRM_STAT_DONE]});
        if (rd_data[`DSPRM_STAT_DONE] !== 1'b1) test_done();
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        reset <= 1'b1;
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        foreach (ROWS[i]) begin
            apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].wdata, i == $size(ROWS) - 1);
            if (!ROWS[i].wr) chk("row read", ROWS[i].exp, rd_data);
            chk("row error", {31'h0, ROWS[i].err}, {31'h0, rd_err});
        end
        chk("word addr", 32'h3fffffff, {2'h0, op_word_addr});
        chk("word count", 32'h3fffffff, {2'h0, op_word_count});
        chk("seed", 32'ha5a5a5a5, op_seed);
        apb(1'b1, `DSPRM_OFS_CH1, 32'h1);
        apb(1'b0, `DSPRM_OFS_STAT, 32'h0);
        chk("dirty after write", 32'h8, rd_data & 32'hc);
        apb(1'b0, `DSPRM_OFS_CH1, 32'h0);
        apb(1'b0, `DSPRM_OFS_STAT, 32'h0);
        chk("dirty after read", 32'h0, rd_data & 32'hc);
        apb(1'b1, `DSPRM_OFS_ADDR, 32'h00000101);
        apb(1'b1, `DSPRM_OFS_LEN, 32'h00000010);
        apb(1'b1, `DSPRM_OFS_DATA, 32'h13579bdf);
        chk("selector", 32'h1, {30'h0, operation_access_selector});
        chk("word addr", 32'h40, {2'h0, op_word_addr});
        chk("word count", 32'h4, {2'h0, op_word_count});
        apb(1'b1, `DSPRM_OFS_CTRL, 32'h0);
        chk("idle pulses", 32'h0, csum_cnt + memory_self_test_cnt);
        apb(1'b1, `DSPRM_OFS_CTRL, 32'h4);
        chk("csum pulses", 32'h1, csum_cnt);
        wait_done();
        apb(1'b0, `DSPRM_OFS_DATA, 32'h0);
        chk("result", 32'h13579be3, rd_data);
        apb(1'b1, `DSPRM_OFS_CTRL, 32'h8);
        chk("self-test pulses", 32'h1, memory_self_test_cnt);
        wait_done();
        apb(1'b1, `DSPRM_OFS_CH0, 32'hffffffff);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        foreach (RST_OFS[i]) begin
            apb(1'b0, RST_OFS[i], 32'h0);
            chk("reset value", 32'h0, rd_data);
        end
        test_done();
    end
endmodule
